// *** core/i2c_freq_control_slave.sv ***
// Two-wire serial slave that holds the frequency control word of a digitally tuned oscillator.
`include "freq_ctrl_defines.svh"
`default_nettype none
module i2c_freq_control_slave #(
  parameter logic [3:0] FACTORY_ADDR_CODE   = 4'h0,
  parameter logic [3:0] PULL_RANGE_RESET    = 4'h0,
  parameter int unsigned PULL_LATENCY_CYCLES = `PULL_START_LATENCY_US * `SYS_CLK_MHZ
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output var  logic                          sda_out_q,
  output var  logic                          sda_oe_b_q,
  input  wire logic                          addr_mode_pin_sel,
  input  wire logic                          addr_select_pin_hi,
  input  wire logic                          addr_select_pin_lo,
  output var  freq_ctrl_pkg::freq_ctrl_type  pull_word_q,
  output var  logic                          pull_start_q,
  output var  logic [`PULL_RANGE_WIDTH-1:0]  pull_range_q
);
  import freq_ctrl_pkg::*;

  // Pin order: mode, hi, lo, scl, sda. All come from outside and pass two flops.
  logic [4:0]    pin_meta_q;
  logic [4:0]    pin_sync_q;
  logic          scl_prev_q;
  logic          sda_prev_q;
  i2c_state_type state_q;
  logic [2:0]    bit_cnt_q;
  logic [7:0]    data_q;
  logic          first_q;
  logic          regaddr_q;
  logic          half_q;
  logic          rw_q;
  logic          byte_full_q;
  logic [7:0]    ptr_q;
  logic [7:0]    hold_q;
  logic [15:0]   low_word_q;
  logic [15:0]   high_word_q;

  wire           scl_s     = pin_sync_q[1];
  wire           sda_s     = pin_sync_q[0];
  wire           pin_mode  = pin_sync_q[4];
  wire           start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire           stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire           scl_rise  = scl_s & ~scl_prev_q;
  wire           scl_fall  = ~scl_s & scl_prev_q;
  wire [7:0]     rx_byte   = {data_q[6:0], sda_s};
  wire           byte_done = (state_q == ST_RX) & scl_rise & (bit_cnt_q == 3'h7);
  wire           tx_done   = (state_q == ST_TX) & scl_rise & (bit_cnt_q == 3'h7);
  wire [6:0]     dev_addr;
  wire           addr_match = (rx_byte[7:1] == dev_addr);
  wire           ptr_load   = byte_done & ~first_q & regaddr_q;
  wire           data_byte  = byte_done & ~first_q & ~regaddr_q;
  wire           wr_commit  = data_byte & half_q;
  wire           rd_commit  = tx_done & half_q;
  wire           pull_commit = wr_commit & (ptr_q == `REG_HIGH_WORD_ADDR);
  wire [15:0]    rd_word;
  wire [7:0]     tx_next    = half_q ? rd_word[7:0] : rd_word[15:8];

  // Register read decode; unmapped offsets and unused range bits read as zero.
  function automatic logic [15:0] reg_read(input logic [7:0] addr, input logic [15:0] lo,
                                           input logic [15:0] hi, input logic [3:0] range);
    logic [15:0] val;
    val = 16'h0000;
    if (addr == `REG_LOW_WORD_ADDR)
      val = lo;
    else if (addr == `REG_HIGH_WORD_ADDR)
      val = hi;
    else if (addr == `REG_PULL_RANGE_ADDR)
      val = {12'h000, range};
    return val;
  endfunction

  assign rd_word  = reg_read(ptr_q, low_word_q, high_word_q, pull_range_q);
  // Factory mode leaves the select pins unread; pin mode places them at bits three and one.
  assign dev_addr = pin_mode ? {`DEV_ADDR_PREFIX, pin_sync_q[3], 1'b0, pin_sync_q[2], 1'b0}
                             : {`DEV_ADDR_PREFIX, FACTORY_ADDR_CODE};

  always_ff @(posedge sys_clk)
  begin
    pin_meta_q <= {addr_mode_pin_sel, addr_select_pin_hi, addr_select_pin_lo, scl_in, sda_in};
    pin_sync_q <= pin_meta_q;
    scl_prev_q <= pin_sync_q[1];
    sda_prev_q <= pin_sync_q[0];
    sda_out_q  <= 1'b0;
  end

  // Bus sequencer. The pin is only ever pulled low; sda_oe_b_q low means it is pulled.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 3'h0;
      data_q      <= 8'h00;
      first_q     <= 1'b0;
      regaddr_q   <= 1'b0;
      half_q      <= 1'b0;
      rw_q        <= 1'b0;
      byte_full_q <= 1'b0;
      sda_oe_b_q  <= 1'b1;
    end
    else if (start_det)
    begin
      state_q     <= ST_RX;
      bit_cnt_q   <= 3'h0;
      first_q     <= 1'b1;
      half_q      <= 1'b0;
      byte_full_q <= 1'b0;
      sda_oe_b_q  <= 1'b1;
    end
    else if (stop_det)
    begin
      state_q    <= ST_IDLE;
      sda_oe_b_q <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE: ;
        ST_RX:
        begin
          if (scl_rise)
          begin
            data_q    <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 3'h1;
          end
          if (byte_done)
          begin
            if (first_q)
            begin
              if (addr_match)
              begin
                rw_q        <= rx_byte[0];
                regaddr_q   <= ~rx_byte[0];
                first_q     <= 1'b0;
                byte_full_q <= 1'b1;
              end
              else
                state_q <= ST_IDLE;
            end
            else
            begin
              regaddr_q   <= 1'b0;
              half_q      <= regaddr_q ? 1'b0 : ~half_q;
              byte_full_q <= 1'b1;
            end
          end
          if (scl_fall && byte_full_q)
          begin
            sda_oe_b_q  <= 1'b0;
            byte_full_q <= 1'b0;
            state_q     <= ST_RX_ACK;
          end
        end
        ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= 3'h0;
            if (rw_q)
            begin
              state_q    <= ST_TX;
              data_q     <= tx_next;
              sda_oe_b_q <= tx_next[7];
            end
            else
            begin
              state_q    <= ST_RX;
              sda_oe_b_q <= 1'b1;
            end
          end
        end
        ST_TX:
        begin
          if (scl_rise)
          begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
          end
          if (tx_done)
          begin
            byte_full_q <= 1'b1;
            half_q      <= ~half_q;
          end
          if (scl_fall)
          begin
            if (byte_full_q)
            begin
              byte_full_q <= 1'b0;
              sda_oe_b_q  <= 1'b1;
              state_q     <= ST_TX_ACK;
            end
            else
            begin
              data_q     <= {data_q[6:0], 1'b0};
              sda_oe_b_q <= data_q[6];
            end
          end
        end
        ST_TX_ACK:
        begin
          // An acknowledge ends the read so the master can stop; a missing one gets the next byte.
          if (scl_rise)
            byte_full_q <= ~sda_s;
          if (scl_fall)
          begin
            if (byte_full_q)
            begin
              state_q     <= ST_IDLE;
              byte_full_q <= 1'b0;
              sda_oe_b_q  <= 1'b1;
            end
            else
            begin
              state_q    <= ST_TX;
              bit_cnt_q  <= 3'h0;
              data_q     <= tx_next;
              sda_oe_b_q <= tx_next[7];
            end
          end
        end
        default:
        begin
          state_q    <= ST_IDLE;
          sda_oe_b_q <= 1'b1;
        end
      endcase
    end
  end

  // The pointer wraps naturally in eight bits.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      ptr_q <= `REG_PTR_RESET;
    else if (ptr_load)
      ptr_q <= rx_byte;
    else if (wr_commit || rd_commit)
      ptr_q <= ptr_q + 8'h01;
  end

  // The first byte waits in hold_q so that software never sees half a word.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      hold_q       <= 8'h00;
      low_word_q   <= `REG_WORD_RESET;
      high_word_q  <= `REG_WORD_RESET;
      pull_range_q <= PULL_RANGE_RESET;
    end
    else if (data_byte && !half_q)
      hold_q <= rx_byte;
    else if (wr_commit)
    begin
      if (ptr_q == `REG_LOW_WORD_ADDR)
        low_word_q <= {hold_q, rx_byte};
      if (ptr_q == `REG_HIGH_WORD_ADDR)
        high_word_q <= {hold_q, rx_byte};
      if (ptr_q == `REG_PULL_RANGE_ADDR)
        pull_range_q <= rx_byte[3:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      pull_start_q <= 1'b0;
      pull_word_q  <= '0;
    end
    else
    begin
      pull_start_q <= pull_commit;
      if (pull_commit)
        pull_word_q <= {hold_q, rx_byte, low_word_q};
    end
  end

  // Helper counting the wait between a high word commit and the pull start.
  logic [15:0] lat_cnt_q;
  logic        lat_pend_q;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || pull_start_q)
    begin
      lat_cnt_q  <= 16'h0000;
      lat_pend_q <= 1'b0;
    end
    else if (pull_commit || lat_pend_q)
    begin
      lat_cnt_q  <= lat_cnt_q + 16'h0001;
      lat_pend_q <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence word_stored_s;
    wr_commit && ptr_q == `REG_HIGH_WORD_ADDR;
  endsequence
  sequence pull_out_s;
    pull_start_q && pull_word_q.high_word == high_word_q;
  endsequence

  addr_nack_a: assert property (byte_done && first_q && !addr_match |=> state_q == ST_IDLE && sda_oe_b_q)
    else $error("mismatched address was not left alone");
  addr_ack_a: assert property (byte_done && first_q && addr_match |-> ##[1:40] !sda_oe_b_q)
    else $error("matching address was not acknowledged");
  rw_dir_a: assert property (byte_done && first_q && addr_match |=> rw_q == $past(rx_byte[0]))
    else $error("direction bit not captured");
  ptr_load_a: assert property (ptr_load |=> ptr_q == $past(rx_byte))
    else $error("register address not loaded");
  ptr_step_a: assert property (wr_commit || rd_commit |=> ptr_q == 8'($past(ptr_q) + 8'h01))
    else $error("pointer did not advance by one");
  ptr_wrap_a: assert property (wr_commit && ptr_q == 8'hFF |=> ptr_q == 8'h00)
    else $error("pointer did not wrap to zero");
  ptr_reset_a: assert property (disable iff (1'b0) !rst_b |=> ptr_q == `REG_PTR_RESET)
    else $error("pointer not zero after reset");
  half_word_a: assert property (data_byte && !half_q |=> $stable(low_word_q) && $stable(high_word_q))
    else $error("register changed on a single byte");
  pull_start_a: assert property (word_stored_s |=> pull_out_s)
    else $error("pull not started with the stored word");
  pull_only_a: assert property (pull_start_q |-> $past(pull_commit))
    else $error("pull started without a high word");
  pull_bound_a: assert property (lat_pend_q |-> lat_cnt_q < 16'(PULL_LATENCY_CYCLES))
    else $error("pull start later than allowed");
  factory_addr_a: assert property (!pin_mode |-> dev_addr == {`DEV_ADDR_PREFIX, FACTORY_ADDR_CODE})
    else $error("factory address wrong");
  pin_addr_a: assert property (pin_mode |-> dev_addr[6:4] == `DEV_ADDR_PREFIX && dev_addr[3] == pin_sync_q[3]
                               && dev_addr[1] == pin_sync_q[2] && !dev_addr[2] && !dev_addr[0])
    else $error("pin selected address wrong");
  restart_a: assert property (start_det |=> state_q == ST_RX && first_q && bit_cnt_q == 3'h0)
    else $error("repeated start not taken");
  tx_msb_a: assert property (state_q == ST_TX_ACK && scl_fall && !byte_full_q && !start_det && !stop_det
                             |=> data_q == $past(tx_next) && sda_oe_b_q == $past(tx_next[7]))
    else $error("next read byte not sent msb first");
  rd_release_a: assert property (state_q == ST_TX_ACK && scl_fall && byte_full_q && !start_det && !stop_det
                                 |=> state_q == ST_IDLE && sda_oe_b_q)
    else $error("data line not released after acknowledged read byte");

endmodule
`default_nettype wire

// *** core/freq_ctrl_defines.svh ***
// Register offsets, reset values and timing figures of the frequency control slave.
`ifndef FREQ_CTRL_DEFINES_SVH
`define FREQ_CTRL_DEFINES_SVH

`define SYS_CLK_MHZ            50
`define PULL_START_LATENCY_US  140
`define DEV_ADDR_PREFIX        3'h6
`define REG_LOW_WORD_ADDR      8'h00
`define REG_HIGH_WORD_ADDR     8'h01
`define REG_PULL_RANGE_ADDR    8'h02
`define REG_WORD_RESET         16'h0000
`define REG_PTR_RESET          8'h00
`define PULL_RANGE_WIDTH       4

`endif

// *** core/freq_ctrl_pkg.sv ***
// Types shared by the frequency control slave.
`default_nettype none
package freq_ctrl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX     = 3'b011,
    ST_TX_ACK = 3'b100
  } i2c_state_type;

  typedef struct packed {
    logic [15:0] high_word;
    logic [15:0] low_word;
  } freq_ctrl_type;

endpackage
`default_nettype wire

// *** verif/i2c_bus_master_model.sv ***
// Behavioural two-wire bus master that talks to the frequency control slave.
`default_nettype none
module i2c_bus_master_model (
  input  wire logic       sys_clk,
  input  wire logic       sda_wire,
  output var  logic       scl_q,
  output var  logic       sda_rel_q,
  output var  logic       res_valid_q,
  output var  logic [7:0] res_val_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // A quarter bit of 13 clocks keeps the bit rate just under 1 Mbit/s.
  localparam int QTR = 13;
  initial
  begin
    scl_q = 1'h1;
    sda_rel_q = 1'h1;
    res_valid_q = 1'h0;
    res_val_q = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic post(input logic [7:0] v);
    res_val_q = v;
    res_valid_q = 1'h1;
    tick(1);
    res_valid_q = 1'h0;
  endtask
  // Data changes only while the clock is low, well after the device has moved.
  task automatic bit_io(input logic b, output logic s);
    tick(QTR);
    sda_rel_q = b;
    tick(QTR);
    scl_q = 1'h1;
    tick(QTR);
    s = sda_wire;
    tick(QTR);
    scl_q = 1'h0;
  endtask
  task automatic bus_start();
    tick(QTR);
    sda_rel_q = 1'h1;
    tick(QTR);
    scl_q = 1'h1;
    tick(QTR);
    sda_rel_q = 1'h0;
    tick(QTR);
    scl_q = 1'h0;
  endtask
  task automatic bus_stop();
    tick(QTR);
    sda_rel_q = 1'h0;
    tick(QTR);
    scl_q = 1'h1;
    tick(QTR);
    sda_rel_q = 1'h1;
    tick(QTR);
  endtask
  task automatic put_byte(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(v[i], s);
    end
    bit_io(1'h1, s);
    post({7'h00, s});
  endtask
  // Earlier bytes are refused so the device keeps sending; only the last is acknowledged.
  task automatic get_byte(input logic last);
    logic [7:0] d;
    logic       s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'h1, d[i]);
    end
    post(d);
    bit_io(!last, s);
  endtask
endmodule
`default_nettype wire

// *** verif/i2c_freq_control_slave_test.sv ***
// Self-checking bench for the frequency control slave driven by a behavioural master.
`default_nettype none
module i2c_freq_control_slave_test;
  timeunit 1ns;
  timeprecision 1ps;
  import freq_ctrl_pkg::*;
  // Factory code 5 gives the device address 1100101.
  localparam logic [6:0] FACTORY_ADDR = 7'h65;
  logic          sys_clk;
  logic          rst_b;
  logic          mode_sel;
  logic          pin_hi;
  logic          pin_lo;
  logic          sda_oe_b_q;
  logic          sda_out_q;
  logic          sda_wire;
  logic          scl;
  logic          sda_rel;
  logic          res_valid;
  logic [7:0]    res_val;
  freq_ctrl_type pull_word_q;
  logic          pull_start_q;
  logic [3:0]    pull_range_q;
  logic [31:0]   rng;
  logic [7:0]    wq[$];
  logic [7:0]    rq[$];
  logic [7:0]    exp_res[$];
  logic [31:0]   exp_pull[$];
  logic [15:0]   lo;
  logic [15:0]   hi;
  int            num_errors;
  int            samples_checked;
  assign sda_wire = (sda_oe_b_q ? 1'h1 : sda_out_q) & sda_rel;
  i2c_freq_control_slave #(
    .FACTORY_ADDR_CODE  (4'h5),
    .PULL_RANGE_RESET   (4'h9),
    .PULL_LATENCY_CYCLES(8)
  ) i_i2c_freq_control_slave (
    .sys_clk           (sys_clk),
    .rst_b             (rst_b),
    .scl_in            (scl),
    .sda_in            (sda_wire),
    .sda_out_q         (sda_out_q),
    .sda_oe_b_q        (sda_oe_b_q),
    .addr_mode_pin_sel (mode_sel),
    .addr_select_pin_hi(pin_hi),
    .addr_select_pin_lo(pin_lo),
    .pull_word_q       (pull_word_q),
    .pull_start_q      (pull_start_q),
    .pull_range_q      (pull_range_q)
  );
  i2c_bus_master_model i_i2c_bus_master_model (
    .sys_clk    (sys_clk),
    .sda_wire   (sda_wire),
    .scl_q      (scl),
    .sda_rel_q  (sda_rel),
    .res_valid_q(res_valid),
    .res_val_q  (res_val)
  );
  initial
  begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic settle();
    repeat (20) @(negedge sys_clk);
    check("pending", exp_res.size() + exp_pull.size(), 0);
  endtask
  // Sends wq after the address only when ok, else drops it; ok tells whether the address should be acknowledged.
  task automatic xfer_wr(input logic [6:0] a, input logic ok, input logic stop);
    i_i2c_bus_master_model.bus_start();
    exp_res.push_back({7'h00, !ok});
    i_i2c_bus_master_model.put_byte({a, 1'h0});
    while (ok && wq.size() > 0)
    begin
      exp_res.push_back(8'h00);
      i_i2c_bus_master_model.put_byte(wq.pop_front());
    end
    wq.delete();
    if (stop)
    begin
      i_i2c_bus_master_model.bus_stop();
      settle();
    end
  endtask
  task automatic xfer_rd(input logic [6:0] a);
    int n;
    n = rq.size();
    i_i2c_bus_master_model.bus_start();
    exp_res.push_back(8'h00);
    i_i2c_bus_master_model.put_byte({a, 1'h1});
    for (int i = 0; i < n; i++)
    begin
      exp_res.push_back(rq.pop_front());
      i_i2c_bus_master_model.get_byte(i == n - 1);
    end
    i_i2c_bus_master_model.bus_stop();
    settle();
  endtask
  always @(posedge sys_clk)
  begin
    if (res_valid === 1'h1)
      check("bus_byte", {24'h00_0000, res_val}, {24'h00_0000, exp_res.size() > 0 ? exp_res.pop_front() : ~res_val});
    if (pull_start_q !== 1'h0)
      check("pull_word", pull_word_q, exp_pull.size() > 0 ? exp_pull.pop_front() : ~pull_word_q);
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    check("watchdog", 32'h0000_0001, 32'h0000_0000);
    summarize();
  end
  initial
  begin
    rng = 32'h0000_554C;
    rst_b = 1'h0;
    mode_sel = 1'h0;
    pin_hi = 1'h0;
    pin_lo = 1'h1;
    num_errors = 0;
    samples_checked = 0;
    repeat (8) @(negedge sys_clk);
    rst_b = 1'h1;
    repeat (4) @(negedge sys_clk);
    check("range_reset", {28'h000_0000, pull_range_q}, 32'h0000_0009);
    rq = '{8'h00, 8'h00, 8'h00, 8'h00};
    xfer_rd(FACTORY_ADDR);
    wq = '{8'h00};
    xfer_wr(7'h60, 1'h0, 1'h1);
    for (int k = 0; k < 3; k++)
    begin
      lo = 16'(xs());
      hi = 16'(xs());
      {pin_hi, pin_lo} = lo[1:0];
      exp_pull.push_back({hi, lo});
      wq = '{8'h00, lo[15:8], lo[7:0], hi[15:8], hi[7:0]};
      xfer_wr(FACTORY_ADDR, 1'h1, 1'h1);
    end
    // A lone low word plus an odd byte must neither start a pull nor touch the high word.
    lo = 16'(xs());
    wq = '{8'h00, lo[15:8], lo[7:0], 8'hA5};
    xfer_wr(FACTORY_ADDR, 1'h1, 1'h1);
    wq = '{8'h00};
    xfer_wr(FACTORY_ADDR, 1'h1, 1'h0);
    rq = '{lo[15:8], lo[7:0], hi[15:8], hi[7:0]};
    xfer_rd(FACTORY_ADDR);
    wq = '{8'hFF, 8'h12, 8'h34, hi[7:0], lo[15:8]};
    xfer_wr(FACTORY_ADDR, 1'h1, 1'h1);
    rq = '{hi[15:8], hi[7:0]};
    xfer_rd(FACTORY_ADDR);
    wq = '{8'h00};
    xfer_wr(FACTORY_ADDR, 1'h1, 1'h1);
    rq = '{hi[7:0], lo[15:8]};
    xfer_rd(FACTORY_ADDR);
    mode_sel = 1'h1;
    for (int p = 0; p < 4; p++)
    begin
      {pin_hi, pin_lo} = 2'(p);
      repeat (8) @(negedge sys_clk);
      wq = '{8'h00};
      xfer_wr({3'h6, pin_hi, 1'h0, pin_lo, 1'h0}, 1'h1, 1'h1);
      xfer_wr({3'h6, ~pin_hi, 1'h0, pin_lo, 1'h0}, 1'h0, 1'h1);
      xfer_wr(FACTORY_ADDR, 1'h0, 1'h1);
    end
    summarize();
  end
endmodule
`default_nettype wire
